// *** common/pmev_pkg.sv ***
// Package of constants for the power-management event front end.
package pmev_pkg;

  // Clock rate in kHz and the debounce interval in milliseconds.
  localparam int unsigned CLK_KHZ      = 125000;
  localparam int unsigned DEBOUNCE_MS  = 16;
  localparam int unsigned DEBOUNCE_CYC = CLK_KHZ * DEBOUNCE_MS;

  // Cycles the external request must stay high before its edge detector rearms.
  localparam int unsigned REARM_CYC = 4;

  // Event source indices within the enable, status and acknowledge vectors.
  localparam int unsigned EV_EXT    = 0;
  localparam int unsigned EV_LID    = 1;
  localparam int unsigned EV_POWER_BUTTON_N = 2;
  localparam int unsigned EV_RING   = 3;
  localparam int unsigned EV_ALERT  = 4;
  localparam int unsigned EV_BUSREQ = 5;
  localparam int unsigned EV_NUM    = 6;

  // Routing codes for the bus alert.
  localparam logic [1:0] ALERT_TO_IRQ    = 2'h0;
  localparam logic [1:0] ALERT_TO_MGMT   = 2'h1;
  localparam logic [1:0] ALERT_TO_RESUME = 2'h2;

  // Reset values.
  localparam logic [5:0] EN_RST   = 6'h00;
  localparam logic [5:0] STAT_RST = 6'h00;

endpackage : pmev_pkg

// *** logic/pmev_debounce.sv ***
// Debounce filter: output follows input after it has held stable for a full interval.
`timescale 1ns/1ps
module pmev_debounce #(
  parameter int unsigned CYCLES = pmev_pkg::DEBOUNCE_CYC,
  parameter logic        INIT   = 1'b1
) (
  // Clock and reset.
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // Raw and filtered level.
  input  wire logic raw_i,
  output logic      clean_o
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         clean_q;
  logic         clean_d;

  // Any bounce restarts the count, so only a level stable for the whole interval passes.
  always_comb
  begin
    cnt_d   = '0;
    clean_d = clean_q;
    if (raw_i != clean_q)
    begin
      if (cnt_q == W'(CYCLES - 1))
        clean_d = raw_i;
      else
        cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_q   <= '0;
      clean_q <= INIT;
    end
    else
    begin
      cnt_q   <= cnt_d;
      clean_q <= clean_d;
    end
  end

  assign clean_o = clean_q;

endmodule : pmev_debounce

// *** logic/pmev_edge.sv ***
// Falling-edge detector for the external request with a rearm hold-off.
`timescale 1ns/1ps
module pmev_edge #(
  parameter int unsigned REARM = pmev_pkg::REARM_CYC
) (
  // Clock and reset.
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // Synchronised request level and detected edge.
  input  wire logic req_n_i,
  output logic      fall_o
);

  localparam int W = $clog2(REARM + 1);

  logic [W-1:0] high_q;
  logic [W-1:0] high_d;
  logic         fall_q;
  logic         fall_d;

  // Count high cycles; a low level only counts as an edge once the detector is armed.
  always_comb
  begin
    high_d = high_q;
    fall_d = 1'b0;
    if (req_n_i)
    begin
      if (high_q != W'(REARM))
        high_d = high_q + 1'b1;
    end
    else
    begin
      fall_d = (high_q == W'(REARM));
      high_d = '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      high_q <= W'(REARM);
      fall_q <= 1'b0;
    end
    else
    begin
      high_q <= high_d;
      fall_q <= fall_d;
    end
  end

  assign fall_o = fall_q;

endmodule : pmev_edge

// *** logic/pmev_top.sv ***
// Power-management event front end: event capture, status flags and output drives.
`timescale 1ns/1ps
module pmev_top #(
  parameter int unsigned DEBOUNCE_CYC = pmev_pkg::DEBOUNCE_CYC,
  parameter int unsigned REARM_CYC    = pmev_pkg::REARM_CYC,
  parameter int unsigned NUM_BUSREQ   = 4
) (
  // Clock and resets.
  input  wire logic                       sys_clk_i,
  input  wire logic                       nrst_i,
  input  wire logic                       resume_well_reset_n_i,
  // External management request, open drain.
  input  wire logic                       ext_mgmt_req_n_i,
  output logic                            ext_mgmt_req_n_o,
  output logic                            ext_mgmt_req_n_oe_o,
  input  wire logic                       serirq_mgmt_req_i,
  // Event inputs.
  input  wire logic                       general_input_lid_i,
  input  wire logic                       power_button_n_i,
  input  wire logic                       ring_wake_n_i,
  input  wire logic                       bus_alert_n_i,
  input  wire logic [NUM_BUSREQ-1:0]      bus_master_req_mon_n_i,
  // Control from the configuration side.
  input  wire logic [pmev_pkg::EV_NUM-1:0] event_en_i,
  input  wire logic [pmev_pkg::EV_NUM-1:0] event_ack_i,
  input  wire logic [1:0]                 alert_route_i,
  input  wire logic                       clk_stop_func_en_i,
  input  wire logic                       clk_stop_req_i,
  input  wire logic                       general_output_clkstop_i,
  // Bus clock and data pins.
  input  wire logic                       bus_scl_i,
  input  wire logic                       bus_sda_i,
  output logic                            bus_scl_o,
  output logic                            bus_scl_oe_o,
  output logic                            bus_sda_o,
  output logic                            bus_sda_oe_o,
  // Results.
  output logic                            mgmt_irq_to_cpu_n_o,
  output logic                            alert_irq_o,
  output logic                            resume_event_o,
  output logic [pmev_pkg::EV_NUM-1:0]     event_status_o,
  output logic                            lid_level_o,
  output logic                            power_button_level_o,
  output logic                            ring_level_o,
  output logic                            alert_level_o,
  output logic                            bus_activity_o,
  output logic                            bus_clk_stop_n_o
);

  localparam int unsigned N = pmev_pkg::EV_NUM;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic       ext_s1_q;
  logic       ext_s2_q;
  logic [3:0] lvl_s1_q;
  logic [3:0] lvl_s2_q;

  // The request is asynchronous, so it gets two flops before any logic looks at it.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
    end
    else
    begin
      ext_s1_q <= ext_mgmt_req_n_i;
      ext_s2_q <= ext_s1_q;
    end
  end

  // Suspend-well inputs are synchronised under the resume-well reset.
  always_ff @(posedge sys_clk_i or negedge resume_well_reset_n_i)
  begin
    if (!resume_well_reset_n_i)
    begin
      lvl_s1_q <= 4'hF;
      lvl_s2_q <= 4'hF;
    end
    else
    begin
      lvl_s1_q <= {bus_alert_n_i, ring_wake_n_i, power_button_n_i, general_input_lid_i};
      lvl_s2_q <= lvl_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and debounce.

  logic ext_fall;
  logic lid_clean;
  logic pwr_clean;

  pmev_edge #(
    .REARM (REARM_CYC)
  ) u_ext_edge (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .req_n_i   (ext_s2_q),
    .fall_o    (ext_fall)
  );

  pmev_debounce #(
    .CYCLES (DEBOUNCE_CYC),
    .INIT   (1'b1)
  ) u_lid_db (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (resume_well_reset_n_i),
    .raw_i     (lvl_s2_q[0]),
    .clean_o   (lid_clean)
  );

  pmev_debounce #(
    .CYCLES (DEBOUNCE_CYC),
    .INIT   (1'b1)
  ) u_pwr_db (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (resume_well_reset_n_i),
    .raw_i     (lvl_s2_q[1]),
    .clean_o   (pwr_clean)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event raw pulses and sticky status.

  logic         lid_prev_q;
  logic         pwr_prev_q;
  logic         ring_prev_q;
  logic         alert_prev_q;
  logic         busact_prev_q;
  logic         busact;
  logic [N-1:0] raw_ev;
  logic [N-1:0] stat_q;
  logic [N-1:0] stat_d;

  assign busact = ~&bus_master_req_mon_n_i;

  // Each event is a one-cycle pulse; the lid fires on both edges, the rest on assertion.
  always_comb
  begin
    raw_ev                      = '0;
    raw_ev[pmev_pkg::EV_EXT]    = ext_fall;
    raw_ev[pmev_pkg::EV_LID]    = lid_clean ^ lid_prev_q;
    raw_ev[pmev_pkg::EV_POWER_BUTTON_N] = pwr_prev_q & ~pwr_clean;
    raw_ev[pmev_pkg::EV_RING]   = ring_prev_q & ~lvl_s2_q[2];
    raw_ev[pmev_pkg::EV_ALERT]  = alert_prev_q & ~lvl_s2_q[3];
    raw_ev[pmev_pkg::EV_BUSREQ] = busact & ~busact_prev_q;
  end

  // A set in the same cycle as an acknowledge wins, so no event is lost.
  always_comb
  begin
    stat_d = (stat_q & ~event_ack_i) | (raw_ev & event_en_i);
  end

  always_ff @(posedge sys_clk_i or negedge resume_well_reset_n_i)
  begin
    if (!resume_well_reset_n_i)
    begin
      stat_q        <= pmev_pkg::STAT_RST;
      lid_prev_q    <= 1'b1;
      pwr_prev_q    <= 1'b1;
      ring_prev_q   <= 1'b1;
      alert_prev_q  <= 1'b1;
      busact_prev_q <= 1'b0;
    end
    else
    begin
      stat_q        <= stat_d;
      lid_prev_q    <= lid_clean;
      pwr_prev_q    <= pwr_clean;
      ring_prev_q   <= lvl_s2_q[2];
      alert_prev_q  <= lvl_s2_q[3];
      busact_prev_q <= busact;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drives, registered apart from the tied-off pin values.

  logic       mgmt_n_q;
  logic       mgmt_n_d;
  logic       irq_q;
  logic       irq_d;
  logic       res_q;
  logic       res_d;
  logic       drive_q;
  logic       drive_d;
  logic       stop_n_q;
  logic       stop_n_d;
  logic [3:0] lvl_q;
  logic       act_q;
  logic       alert_st;

  assign alert_st = stat_q[pmev_pkg::EV_ALERT];

  // Management line is held low while any routed flag is pending; stored inverted so the pin is a flop.
  always_comb
  begin
    mgmt_n_d = ~(stat_q[pmev_pkg::EV_EXT] | stat_q[pmev_pkg::EV_LID]
             | stat_q[pmev_pkg::EV_POWER_BUTTON_N]
             | (alert_st && alert_route_i == pmev_pkg::ALERT_TO_MGMT));
    irq_d  = alert_st && alert_route_i == pmev_pkg::ALERT_TO_IRQ;
    res_d  = stat_q[pmev_pkg::EV_RING]
           | (alert_st && alert_route_i == pmev_pkg::ALERT_TO_RESUME);
    drive_d  = serirq_mgmt_req_i;
    stop_n_d = clk_stop_func_en_i ? ~clk_stop_req_i : general_output_clkstop_i;
  end

  // The clock-stop request relies on this block's clock staying free-running.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mgmt_n_q <= 1'b1;
      irq_q    <= 1'b0;
      res_q    <= 1'b0;
      drive_q  <= 1'b0;
      stop_n_q <= 1'b1;
      lvl_q    <= 4'hF;
      act_q    <= 1'b0;
    end
    else
    begin
      mgmt_n_q <= mgmt_n_d;
      irq_q    <= irq_d;
      res_q    <= res_d;
      drive_q  <= drive_d;
      stop_n_q <= stop_n_d;
      lvl_q    <= lvl_s2_q;
      act_q    <= busact;
    end
  end

  assign mgmt_irq_to_cpu_n_o  = mgmt_n_q;
  assign alert_irq_o          = irq_q;
  assign resume_event_o       = res_q;
  assign event_status_o       = stat_q;
  assign ext_mgmt_req_n_o     = 1'b0;
  assign ext_mgmt_req_n_oe_o  = drive_q;
  assign bus_clk_stop_n_o     = stop_n_q;
  assign lid_level_o          = lvl_q[0];
  assign power_button_level_o = lvl_q[1];
  assign ring_level_o         = lvl_q[2];
  assign alert_level_o        = lvl_q[3];
  assign bus_activity_o       = act_q;

  // The bus pins are never driven or read here; the controller lives elsewhere.
  assign bus_scl_o    = 1'b0;
  assign bus_scl_oe_o = 1'b0;
  assign bus_sda_o    = 1'b0;
  assign bus_sda_oe_o = 1'b0;

endmodule : pmev_top

// *** bench/pmev_event_src.sv ***
// Model of the external requester sharing the open-drain request line.
`timescale 1ns/1ps
module pmev_event_src (
  // Clock.
  input  wire logic sys_clk_i,
  // Bench request and the block's own open-drain drive.
  input  wire logic fire_i,
  input  wire logic pull_oe_i,
  input  wire logic pull_val_i,
  // Resolved line level.
  output logic      line_o
);
  logic       low_q;
  logic [2:0] hold_q = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // One clock low per request; a request inside the high hold-off is dropped.
  // The model has no reset, so the hold counter starts from its declared value.
  always @(posedge sys_clk_i)
  begin
    low_q <= fire_i && !low_q && hold_q >= 3'h4;
    if (low_q)
      hold_q <= 3'h0;
    else if (hold_q != 3'h7)
      hold_q <= hold_q + 3'h1;
  end

  // The pull-up holds the line high unless a party pulls it low.
  assign line_o = !(low_q || (pull_oe_i && !pull_val_i));
endmodule : pmev_event_src

// *** bench/pmev_top_properties.sv ***
// Concurrent checks on the ports of the event front end.
`timescale 1ns/1ps
module pmev_top_properties (
  // Clock, resets and inputs.
  input wire logic       sys_clk_i,
  input wire logic       nrst_i,
  input wire logic       ext_mgmt_req_n_i,
  input wire logic       serirq_mgmt_req_i,
  input wire logic [5:0] event_en_i,
  input wire logic [5:0] event_ack_i,
  input wire logic [1:0] alert_route_i,
  input wire logic       clk_stop_func_en_i,
  input wire logic       clk_stop_req_i,
  input wire logic       general_output_clkstop_i,
  input wire logic       resume_well_reset_n_i,
  // Outputs under watch.
  input wire logic       ext_mgmt_req_n_o,
  input wire logic       ext_mgmt_req_n_oe_o,
  input wire logic       bus_scl_oe_o,
  input wire logic       bus_sda_oe_o,
  input wire logic       mgmt_irq_to_cpu_n_o,
  input wire logic       alert_irq_o,
  input wire logic       resume_event_o,
  input wire logic [5:0] event_status_o,
  input wire logic       bus_clk_stop_n_o
);
  logic       mgmt_c, airq_c, resm_c, stop_c;
  logic [5:0] keep_c;

  // Causes that each registered output follows one clock later.
  assign mgmt_c = |event_status_o[2:0] | (event_status_o[4] & (alert_route_i == 2'h1));
  assign airq_c = event_status_o[4] & (alert_route_i == 2'h0);
  assign resm_c = event_status_o[3] | (event_status_o[4] & (alert_route_i == 2'h2));
  assign stop_c = clk_stop_func_en_i ? !clk_stop_req_i : general_output_clkstop_i;
  assign keep_c = event_status_o & ~event_ack_i;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Checks guarded by $past(nrst_i) skip the first edge after reset: the registers held reset values.
  a_pins_never_driven: assert property (!bus_scl_oe_o && !bus_sda_oe_o)
    else $error("bus pin driven");
  a_pull_follows_req: assert property ($past(nrst_i) |->
    ext_mgmt_req_n_oe_o == $past(serirq_mgmt_req_i))
    else $error("pull enable wrong");
  a_pull_value_low: assert property (ext_mgmt_req_n_oe_o |-> !ext_mgmt_req_n_o)
    else $error("pull value high");
  a_mgmt_from_status: assert property ($past(nrst_i) |->
    mgmt_irq_to_cpu_n_o == !$past(mgmt_c))
    else $error("mgmt output wrong");
  a_alert_irq_route: assert property ($past(nrst_i) |-> alert_irq_o == $past(airq_c))
    else $error("alert irq wrong");
  a_resume_from_status: assert property ($past(nrst_i) |->
    resume_event_o == $past(resm_c))
    else $error("resume event wrong");
  a_clk_stop_drive: assert property ($past(nrst_i) |-> bus_clk_stop_n_o == $past(stop_c))
    else $error("clock stop wrong");
  a_status_sticky: assert property (disable iff (!nrst_i || !resume_well_reset_n_i)
    (event_status_o & $past(keep_c)) == $past(keep_c))
    else $error("status lost");
  a_disabled_no_set: assert property (
    (event_status_o & ~$past(event_status_o) & ~$past(event_en_i)) == 6'h00)
    else $error("disabled event set");
  a_ext_edge_cause: assert property ($rose(event_status_o[0]) |->
    !$past(ext_mgmt_req_n_i, 4) || !$past(ext_mgmt_req_n_i, 5)
    || !$past(ext_mgmt_req_n_i, 6))
    else $error("ext status without edge");
endmodule : pmev_top_properties

bind pmev_top pmev_top_properties chk_u (.sys_clk_i, .nrst_i, .ext_mgmt_req_n_i,
  .serirq_mgmt_req_i, .event_en_i, .event_ack_i, .alert_route_i, .clk_stop_func_en_i,
  .clk_stop_req_i, .general_output_clkstop_i, .resume_well_reset_n_i, .ext_mgmt_req_n_o,
  .ext_mgmt_req_n_oe_o, .bus_scl_oe_o, .bus_sda_oe_o, .mgmt_irq_to_cpu_n_o, .alert_irq_o,
  .resume_event_o, .event_status_o, .bus_clk_stop_n_o);

// *** bench/pmev_top_bench.sv ***
// Self-checking bench for the event front end.
`timescale 1ns/1ps
module pmev_top_bench;
  logic       sys_clk, nrst, rrst, fire, serirq, lid, pwr, ring, alrt, csf, csr, gpo;
  logic [3:0] breq;
  logic [5:0] en, ack, st;
  logic [1:0] route;
  logic       line, od, oe, mgmt_n, airq, resm, lidl, ringl, act, stop_n, soe, doe;
  logic       pwrl, alrtl, sclo, sdao;
  int         err_total, checked, cyc;

  // Short debounce keeps the run brief; expectations use the same eight.
  pmev_top #(.DEBOUNCE_CYC(8)) dut_u (.sys_clk_i(sys_clk), .nrst_i(nrst),
    .resume_well_reset_n_i(rrst), .ext_mgmt_req_n_i(line), .ext_mgmt_req_n_o(od),
    .ext_mgmt_req_n_oe_o(oe), .serirq_mgmt_req_i(serirq), .general_input_lid_i(lid),
    .power_button_n_i(pwr), .ring_wake_n_i(ring), .bus_alert_n_i(alrt),
    .bus_master_req_mon_n_i(breq), .event_en_i(en), .event_ack_i(ack),
    .alert_route_i(route), .clk_stop_func_en_i(csf), .clk_stop_req_i(csr),
    .general_output_clkstop_i(gpo), .bus_scl_i(1'b1), .bus_sda_i(1'b1), .bus_scl_o(sclo),
    .bus_scl_oe_o(soe), .bus_sda_o(sdao), .bus_sda_oe_o(doe), .mgmt_irq_to_cpu_n_o(mgmt_n),
    .alert_irq_o(airq), .resume_event_o(resm), .event_status_o(st), .lid_level_o(lidl),
    .power_button_level_o(pwrl), .ring_level_o(ringl), .alert_level_o(alrtl),
    .bus_activity_o(act), .bus_clk_stop_n_o(stop_n));

  // Requester on the shared line.
  pmev_event_src src_u (.sys_clk_i(sys_clk), .fire_i(fire), .pull_oe_i(oe),
    .pull_val_i(od), .line_o(line));

  // Free-running clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // A hang is cut short well past the expected few hundred cycles.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Waits a bounded time for a status flag, sampling at falling edges.
  task automatic wait_ev(input int i, input int lim);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (st[i] !== 1'b1 && k < lim)
    begin
      @(negedge sys_clk);
      k++;
    end
    chk(st[i], 1'b1);
  endtask : wait_ev

  task automatic clear_ev(input int i);
    tick(1);
    ack[i] <= 1'b1;
    tick(1);
    ack[i] <= 1'b0;
    @(negedge sys_clk);
    chk(st[i], 1'b0);
  endtask : clear_ev

  ////////////////////////////////////////////////////////////////////////////
  // A one-clock request is ignored while disabled and caught once enabled.
  task automatic ext_case();
    tick(1);
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
    tick(10);
    @(negedge sys_clk);
    chk(st[0], 1'b0);
    tick(1);
    en <= 6'h01;
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
    wait_ev(0, 8);
    @(negedge sys_clk);
    chk(mgmt_n, 1'b0);
    clear_ev(0);
  endtask : ext_case

  task automatic serirq_case();
    tick(1);
    en <= 6'h00;
    serirq <= 1'b1;
    tick(2);
    @(negedge sys_clk);
    chk({oe, line}, 8'h02);
    tick(1);
    serirq <= 1'b0;
    tick(2);
    @(negedge sys_clk);
    chk({oe, line}, 8'h01);
  endtask : serirq_case

  // A short glitch is filtered; both lasting transitions raise the event.
  task automatic lid_case();
    tick(1);
    lid <= 1'b0;
    tick(20);
    @(negedge sys_clk);
    chk({lidl, st[1]}, 8'h00);
    tick(1);
    en <= 6'h02;
    lid <= 1'b1;
    tick(3);
    lid <= 1'b0;
    tick(20);
    @(negedge sys_clk);
    chk(st[1], 1'b0);
    tick(1);
    lid <= 1'b1;
    tick(6);
    @(negedge sys_clk);
    chk(st[1], 1'b0);
    wait_ev(1, 20);
    @(negedge sys_clk);
    chk(mgmt_n, 1'b0);
    clear_ev(1);
    tick(1);
    lid <= 1'b0;
    wait_ev(1, 30);
    clear_ev(1);
  endtask : lid_case

  task automatic pwr_case();
    tick(1);
    en <= 6'h04;
    pwr <= 1'b0;
    tick(6);
    @(negedge sys_clk);
    chk({pwrl, st[2]}, 8'h00);
    wait_ev(2, 20);
    @(negedge sys_clk);
    chk(mgmt_n, 1'b0);
    tick(1);
    pwr <= 1'b1;
    tick(14);
    clear_ev(2);
  endtask : pwr_case

  // The ring level reads back while disabled, and wakes once enabled.
  task automatic ring_case();
    tick(1);
    en <= 6'h00;
    ring <= 1'b0;
    tick(5);
    @(negedge sys_clk);
    chk({ringl, st[3]}, 8'h00);
    tick(1);
    ring <= 1'b1;
    tick(4);
    en <= 6'h08;
    ring <= 1'b0;
    wait_ev(3, 8);
    @(negedge sys_clk);
    chk({resm, mgmt_n}, 8'h03);
    tick(1);
    ring <= 1'b1;
    clear_ev(3);
  endtask : ring_case

  task automatic alert_case();
    int r;
    for (r = 0; r < 3; r++)
    begin
      tick(1);
      en <= 6'h10;
      route <= r[1:0];
      alrt <= 1'b0;
      wait_ev(4, 8);
      @(negedge sys_clk);
      chk({alrtl, airq, !mgmt_n, resm}, 8'h04 >> r);
      tick(1);
      alrt <= 1'b1;
      clear_ev(4);
    end
  endtask : alert_case

  task automatic busreq_case();
    int i;
    for (i = 0; i < 4; i++)
    begin
      tick(1);
      en <= 6'h20;
      breq <= ~(4'h1 << i);
      tick(4);
      @(negedge sys_clk);
      chk({act, st[5]}, 8'h03);
      tick(1);
      breq <= 4'hF;
      clear_ev(5);
    end
  endtask : busreq_case

  task automatic clkstop_case();
    int k;
    for (k = 0; k < 4; k++)
    begin
      tick(1);
      csf <= k[1];
      csr <= k[0];
      gpo <= k[0];
      tick(2);
      @(negedge sys_clk);
      chk({stop_n, soe, doe, sclo, sdao}, {k[1] ? !k[0] : k[0], 4'h0});
    end
  endtask : clkstop_case

  // Resume reset clears flags but leaves the main-reset clock-stop drive.
  task automatic resume_case();
    tick(1);
    en <= 6'h08;
    ring <= 1'b0;
    wait_ev(3, 8);
    tick(1);
    rrst <= 1'b0;
    ring <= 1'b1;
    tick(1);
    rrst <= 1'b1;
    tick(2);
    @(negedge sys_clk);
    chk({st, resm, stop_n}, 8'h00);
  endtask : resume_case

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst, rrst, fire, serirq, csf, csr, gpo} = 7'h00;
    {lid, pwr, ring, alrt} = 4'hF;
    {en, ack, route, breq} = {6'h00, 6'h00, 2'h0, 4'hF};
    {err_total, checked, cyc} = 96'h0;
    tick(12);
    nrst <= 1'b1;
    rrst <= 1'b1;
    tick(2);
    ext_case();
    serirq_case();
    lid_case();
    pwr_case();
    ring_case();
    alert_case();
    busreq_case();
    clkstop_case();
    resume_case();
    complete_run();
  end
endmodule : pmev_top_bench
